// [logic/iop_map.svh]
// register offsets, reset values and pin positions of the port block
// included by the package and the port module; definitions only
`ifndef IOP_MAP_SVH
`define IOP_MAP_SVH

`define IOP_ADDR_W 8
`define IOP_OFS_DATA 8'h00
`define IOP_OFS_DIR 8'h04
`define IOP_OFS_PULL 8'h08
`define IOP_OFS_LEVEL 8'h0c

`define IOP_RST_DATA 24'h000000
`define IOP_RST_DIR 24'h000000
`define IOP_RST_PULL 24'hffffff
`define IOP_PULL_PRESENT 24'hffffff

`define IOP_RESP_OKAY 2'b00
`define IOP_RESP_SLVERR 2'b10

`define IOP_G0_LSB 0
`define IOP_SER0_LSB 8
`define IOP_SER1_LSB 12
`define IOP_PIN_TMR_A 16
`define IOP_PIN_TMR_B 17
`define IOP_PIN_CLK_OUT 18
`define IOP_PIN_TMR_B_INV 19
`define IOP_PIN_BUS_REQ 20
`define IOP_PIN_BUS_ACK 21
`define IOP_PIN_DISP_CLK 22
`define IOP_PIN_DISP_FRM 23
`define IOP_EXT_CLK_LSB 20

`endif

// [logic/iop_pkg.sv]
// types shared by the port block and whoever connects it
// assumes iop_map.svh sits in the include path
`include "iop_map.svh"
package iop_pkg;

    // drive requests from the peripherals that share the pins
    typedef struct packed {
        logic bus_expansion;
        logic bus_drive;
        logic [7:0] bus_dout;
        logic [3:0] serial0_use;
        logic serial0_tx;
        logic serial0_shift_clock;
        logic serial0_clk_drive;
        logic serial0_ready_out;
        logic [3:0] serial1_use;
        logic serial1_tx;
        logic serial1_shift_clock;
        logic serial1_clk_drive;
        logic serial1_ready_out;
        logic timer_pair_a_en;
        logic timer_pair_a_out;
        logic timer_pair_b_en;
        logic timer_pair_b_inv_en;
        logic timer_pair_b_out;
        logic clock_out_en;
        logic clock_out_pin;
        logic bus_release_en;
        logic bus_release_ack;
        logic display_en;
        logic display_line_clock;
        logic display_frame_signal;
    } iop_periph_out_t;

    // pin levels handed to the peripherals
    typedef struct packed {
        logic [7:0] bus_din;
        logic serial0_rx;
        logic serial0_shift_clock;
        logic serial1_rx;
        logic serial1_shift_clock;
        logic bus_release_request;
        logic [3:0] timer_ext_clock_in;
    } iop_periph_in_t;

    typedef struct packed {
        logic [23:0] data;
        logic [23:0] dir;
        logic [23:0] pull;
        logic [23:0] pin_out;
        logic [23:0] pin_oe_n;
        logic [23:0] pullup_on;
        iop_periph_in_t to_periph;
        logic aw_got;
        logic w_got;
        logic [`IOP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } iop_state_t;

endpackage

// [logic/iop_pin_sharing.sv]
// 24-pin general-purpose port with alternate-function pin sharing
// assumes one 250 MHz clock, pins synchronous to it, AXI4-Lite master
`timescale 1ns/100ps
`include "iop_map.svh"

module iop_pin_sharing (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // axi4-lite write
    input wire logic [`IOP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`IOP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // peripherals
    input wire iop_pkg::iop_periph_out_t periph_out,
    output iop_pkg::iop_periph_in_t periph_in,
    // pads
    input wire logic [23:0] pin_in,
    output logic [23:0] pin_out,
    output logic [23:0] pin_oe_n,
    output logic [23:0] pullup_on
);
    import iop_pkg::*;

    iop_state_t st_r;
    iop_state_t st_nxt;
    logic [23:0] own_w;
    logic [23:0] drv_w;
    logic [23:0] lvl_w;
    logic [23:0] level_w;
    logic wr_fire_w;

    // serial pin order: rx, tx, shift clock, ready
    function automatic logic [11:0] serial_map(input logic [3:0] use_b,
        input logic tx, input logic clk, input logic clk_drv,
        input logic rdy);
        logic [3:0] d;
        logic [3:0] l;
        d = {use_b[3], use_b[2] & clk_drv, use_b[1], 1'b0};
        l = {rdy, clk, tx, 1'b0};
        return {use_b, d, l};
    endfunction

    function automatic logic [23:0] merge(input logic [23:0] old,
        input logic [31:0] wd, input logic [3:0] sb);
        logic [23:0] r;
        r = old;
        for (int b = 0; b < 3; b++) begin
            if (sb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ownership map: which peripheral takes each pin
    always_comb begin
        own_w = 24'h000000;
        drv_w = 24'h000000;
        lvl_w = 24'h000000;
        if (periph_out.bus_expansion) begin
            own_w[`IOP_G0_LSB +: 8] = 8'hff;
            drv_w[`IOP_G0_LSB +: 8] = {8{periph_out.bus_drive}};
            lvl_w[`IOP_G0_LSB +: 8] = periph_out.bus_dout;
        end
        // unused serial roles stay with the port
        {own_w[`IOP_SER0_LSB +: 4], drv_w[`IOP_SER0_LSB +: 4],
            lvl_w[`IOP_SER0_LSB +: 4]} = serial_map(
            periph_out.serial0_use, periph_out.serial0_tx,
            periph_out.serial0_shift_clock, periph_out.serial0_clk_drive,
            periph_out.serial0_ready_out);
        {own_w[`IOP_SER1_LSB +: 4], drv_w[`IOP_SER1_LSB +: 4],
            lvl_w[`IOP_SER1_LSB +: 4]} = serial_map(
            periph_out.serial1_use, periph_out.serial1_tx,
            periph_out.serial1_shift_clock, periph_out.serial1_clk_drive,
            periph_out.serial1_ready_out);
        if (periph_out.timer_pair_a_en) begin
            own_w[`IOP_PIN_TMR_A] = 1'b1;
            drv_w[`IOP_PIN_TMR_A] = 1'b1;
            lvl_w[`IOP_PIN_TMR_A] = periph_out.timer_pair_a_out;
        end
        if (periph_out.timer_pair_b_en) begin
            own_w[`IOP_PIN_TMR_B] = 1'b1;
            drv_w[`IOP_PIN_TMR_B] = 1'b1;
            lvl_w[`IOP_PIN_TMR_B] = periph_out.timer_pair_b_out;
        end
        if (periph_out.timer_pair_b_inv_en) begin
            own_w[`IOP_PIN_TMR_B_INV] = 1'b1;
            drv_w[`IOP_PIN_TMR_B_INV] = 1'b1;
            lvl_w[`IOP_PIN_TMR_B_INV] = ~periph_out.timer_pair_b_out;
        end
        if (periph_out.clock_out_en) begin
            own_w[`IOP_PIN_CLK_OUT] = 1'b1;
            drv_w[`IOP_PIN_CLK_OUT] = 1'b1;
            lvl_w[`IOP_PIN_CLK_OUT] = periph_out.clock_out_pin;
        end
        if (periph_out.bus_release_en) begin
            own_w[`IOP_PIN_BUS_REQ] = 1'b1;
            own_w[`IOP_PIN_BUS_ACK] = 1'b1;
            drv_w[`IOP_PIN_BUS_ACK] = 1'b1;
            lvl_w[`IOP_PIN_BUS_ACK] = periph_out.bus_release_ack;
        end
        if (periph_out.display_en) begin
            own_w[`IOP_PIN_DISP_CLK] = 1'b1;
            own_w[`IOP_PIN_DISP_FRM] = 1'b1;
            drv_w[`IOP_PIN_DISP_CLK] = 1'b1;
            drv_w[`IOP_PIN_DISP_FRM] = 1'b1;
            lvl_w[`IOP_PIN_DISP_CLK] = periph_out.display_line_clock;
            lvl_w[`IOP_PIN_DISP_FRM] = periph_out.display_frame_signal;
        end
    end

    // port read value: live pin in input mode, data bit when output
    assign level_w = (st_r.dir & st_r.data) | (~st_r.dir & pin_in);

    assign wr_fire_w = st_r.aw_got & st_r.w_got & ~st_r.bvalid;

    always_comb begin
        logic [23:0] oe;
        oe = 24'h000000;
        st_nxt = st_r;

        // write channel: address and data taken in either order
        if (s_axi_awvalid & st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_fire_w) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `IOP_RESP_OKAY;
            // owned pins keep their bits as plain storage
            if (st_r.awaddr == `IOP_OFS_DATA) begin
                st_nxt.data = merge(st_r.data, st_r.wdata,
                    st_r.wstrb);
            end else if (st_r.awaddr == `IOP_OFS_DIR) begin
                st_nxt.dir = merge(st_r.dir, st_r.wdata,
                    st_r.wstrb);
            end else if (st_r.awaddr == `IOP_OFS_PULL) begin
                st_nxt.pull = merge(st_r.pull, st_r.wdata,
                    st_r.wstrb);
            end else if (st_r.awaddr != `IOP_OFS_LEVEL) begin
                st_nxt.bresp = `IOP_RESP_SLVERR;
            end
        end
        // each ready only while its own channel is empty and no response is pending, so ready stays registered
        st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
        st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;

        // read channel
        if (s_axi_rvalid & s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid & st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `IOP_RESP_OKAY;
            st_nxt.rdata = 32'h00000000;
            if (s_axi_araddr == `IOP_OFS_DATA) begin
                st_nxt.rdata[23:0] = st_r.data;
            end else if (s_axi_araddr == `IOP_OFS_DIR) begin
                st_nxt.rdata[23:0] = st_r.dir;
            end else if (s_axi_araddr == `IOP_OFS_PULL) begin
                st_nxt.rdata[23:0] = st_r.pull;
            end else if (s_axi_araddr == `IOP_OFS_LEVEL) begin
                st_nxt.rdata[23:0] = level_w;
            end else begin
                st_nxt.rresp = `IOP_RESP_SLVERR;
            end
        end
        st_nxt.arready = ~st_nxt.rvalid;

        // pin mux, registered so pads see no decode glitches
        oe = (own_w & drv_w) | (~own_w & st_r.dir);
        st_nxt.pin_oe_n = ~oe;
        st_nxt.pin_out = (own_w & lvl_w) | (~own_w & st_r.data);
        // pull-up follows its bit on any undriven pin, owned or not
        st_nxt.pullup_on = st_r.pull & `IOP_PULL_PRESENT
            & ~oe;

        // inputs to peripherals; ext clocks read like port inputs
        st_nxt.to_periph.bus_din = pin_in[`IOP_G0_LSB +: 8];
        st_nxt.to_periph.serial0_rx = pin_in[`IOP_SER0_LSB];
        st_nxt.to_periph.serial0_shift_clock = pin_in[`IOP_SER0_LSB + 2];
        st_nxt.to_periph.serial1_rx = pin_in[`IOP_SER1_LSB];
        st_nxt.to_periph.serial1_shift_clock = pin_in[`IOP_SER1_LSB + 2];
        st_nxt.to_periph.bus_release_request = pin_in[`IOP_PIN_BUS_REQ];
        st_nxt.to_periph.timer_ext_clock_in =
            pin_in[`IOP_EXT_CLK_LSB +: 4];
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.data <= `IOP_RST_DATA;
            st_r.dir <= `IOP_RST_DIR;
            st_r.pull <= `IOP_RST_PULL;
            st_r.pin_out <= `IOP_RST_DATA;
            st_r.pin_oe_n <= ~`IOP_RST_DIR;
            st_r.pullup_on <= `IOP_RST_PULL & `IOP_PULL_PRESENT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign pin_out = st_r.pin_out;
    assign pin_oe_n = st_r.pin_oe_n;
    assign pullup_on = st_r.pullup_on;
    assign periph_in = st_r.to_periph;

    a_gpio_oe_dir: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> ((~$past(own_w) & (pin_oe_n ^ ~$past(st_r.dir)))
        == 24'h000000))
        else $error("port pin enable does not follow direction bit");

    a_gpio_out_data: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> ((~$past(own_w) & (pin_out ^ $past(st_r.data)))
        == 24'h000000))
        else $error("port pin level does not follow data bit");

    a_pull_not_driven: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (pullup_on & ~pin_oe_n) == 24'h000000)
        else $error("pull-up on while pin is driven");

    a_pull_from_bit: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        $past(st_r.pull[`IOP_PIN_BUS_REQ]) && pin_oe_n[`IOP_PIN_BUS_REQ]
        |-> pullup_on[`IOP_PIN_BUS_REQ])
        else $error("request pin pull-up lost");

    a_bus_group_zero: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.bus_expansion ##1 1'b1 |-> pin_oe_n[7:0]
        == ~{8{$past(periph_out.bus_drive)}}
        && (pin_out[7:0] == $past(periph_out.bus_dout)
        || !$past(periph_out.bus_drive)))
        else $error("group zero not following data bus");

    a_timer_b_inv: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.timer_pair_b_inv_en |=> !pin_oe_n[`IOP_PIN_TMR_B_INV]
        && pin_out[`IOP_PIN_TMR_B_INV]
        == !$past(periph_out.timer_pair_b_out))
        else $error("inverted timer output wrong");

    a_timer_a_owns: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.timer_pair_a_en |=> !pin_oe_n[`IOP_PIN_TMR_A]
        && !pullup_on[`IOP_PIN_TMR_A]
        && pin_out[`IOP_PIN_TMR_A] == $past(periph_out.timer_pair_a_out))
        else $error("timer output pin not owned by timer");

    a_clock_out_pin: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.clock_out_en |=> !pin_oe_n[`IOP_PIN_CLK_OUT]
        && !pullup_on[`IOP_PIN_CLK_OUT]
        && pin_out[`IOP_PIN_CLK_OUT] == $past(periph_out.clock_out_pin))
        else $error("clock output pin not owned by clock output");

    a_display_pins: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.display_en |=> !pin_oe_n[`IOP_PIN_DISP_CLK]
        && !pin_oe_n[`IOP_PIN_DISP_FRM]
        && pin_out[`IOP_PIN_DISP_CLK]
        == $past(periph_out.display_line_clock)
        && pin_out[`IOP_PIN_DISP_FRM]
        == $past(periph_out.display_frame_signal))
        else $error("display pins not owned by display outputs");

    a_release_ack: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.bus_release_en |=> !pin_oe_n[`IOP_PIN_BUS_ACK]
        && pin_oe_n[`IOP_PIN_BUS_REQ]
        && pin_out[`IOP_PIN_BUS_ACK] == $past(periph_out.bus_release_ack))
        else $error("bus release pins not owned by bus release");

    a_serial_tx: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        periph_out.serial0_use[1] |=> !pin_oe_n[`IOP_SER0_LSB + 1]
        && pin_out[`IOP_SER0_LSB + 1] == $past(periph_out.serial0_tx))
        else $error("serial transmit pin not owned by serial output");

    // reset_n as antecedent skips the edge on which reset lets go
    a_ext_clock_in: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        reset_n |=> periph_in.timer_ext_clock_in
        == $past(pin_in[`IOP_EXT_CLK_LSB +: 4]))
        else $error("external timer clocks not passed to timers");

    a_read_level: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `IOP_OFS_LEVEL
        |=> s_axi_rvalid && s_axi_rdata[23:0] == $past(level_w))
        else $error("level read returned wrong value");

    a_write_data: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wr_fire_w && st_r.awaddr == `IOP_OFS_DATA && st_r.wstrb[2:0] == 3'h7
        |=> st_r.data == $past(st_r.wdata[23:0]) && s_axi_bvalid)
        else $error("data write not stored");

endmodule

// [bench/iop_pad_model.sv]
// pad and external-driver model for the shared-pin port block
// assumes pad levels are sampled on the system clock
`timescale 1ns/100ps

module iop_pad_model (
    // clock
    input wire logic sys_clk,
    // device side
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe_n,
    input wire logic [23:0] pullup_on,
    // external drivers
    input wire logic [23:0] ext_en,
    input wire logic [23:0] ext_val,
    // resolved pad levels
    output logic [23:0] pin_in
);
    // a floating pad flips each cycle so a stale level never looks valid
    always @(posedge sys_clk) begin
        for (int i = 0; i < 24; i++) begin
            if (pin_oe_n[i] === 1'b0)
                pin_in[i] <= pin_out[i];
            else if (ext_en[i])
                pin_in[i] <= ext_val[i];
            else if (pullup_on[i] === 1'b1)
                pin_in[i] <= 1'b1;
            else
                pin_in[i] <= ~pin_in[i];
        end
    end
endmodule

// [bench/tb_iop_pin_sharing.sv]
// self-checking bench for the shared-pin port block
// assumes the pad model and iop_map.svh are compiled alongside
`timescale 1ns/100ps
`include "iop_map.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_iop_pin_sharing;
    import iop_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    iop_periph_out_t po = '0;
    iop_periph_in_t pi;
    logic [23:0] pin_in, pin_out, pin_oe_n, pullup_on;
    logic [23:0] ext_en = 24'h000000;
    logic [23:0] ext_val = 24'h000000;
    int fails = 0;
    int compares = 0;

    always #2 sys_clk = ~sys_clk;

    iop_pin_sharing u_iop_pin_sharing (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .periph_out(po), .periph_in(pi),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on)
    );

    iop_pad_model u_iop_pad_model (
        .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in)
    );

    task automatic summarize;
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // write; both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 || n > 100) begin
                if (n > 100)
                    fails++;
                `CHK(s_axi_bresp, er)
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 || n > 100) begin
                if (n > 100)
                    fails++;
                `CHK(s_axi_rdata, e)
                `CHK(s_axi_rresp, er)
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // pins lag one cycle, the pad model and input sampling one more each
    task automatic settle;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset;
        settle();
        `CHK(pin_oe_n, 24'hffffff)
        `CHK(pullup_on, 24'hffffff)
        rd(`IOP_OFS_DIR, 32'h00000000, `IOP_RESP_OKAY);
        rd(`IOP_OFS_PULL, 32'h00ffffff, `IOP_RESP_OKAY);
        rd(`IOP_OFS_DATA, 32'h00000000, `IOP_RESP_OKAY);
        rd(`IOP_OFS_LEVEL, 32'h00ffffff, `IOP_RESP_OKAY);
        rd(8'h10, 32'h00000000, `IOP_RESP_SLVERR);
        wr(8'h20, 32'h0000ffff, `IOP_RESP_SLVERR);
    endtask

    task automatic t_gpio;
        @(posedge sys_clk);
        ext_en <= 24'h0000f0;
        ext_val <= 24'h0000a0;
        wr(`IOP_OFS_DATA, 32'h0000005a, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_oe_n[7:0], 8'hff)
        wr(`IOP_OFS_DIR, 32'h0000000f, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_oe_n[7:0], 8'hf0)
        `CHK(pin_out[3:0], 4'ha)
        `CHK(pullup_on[7:0], 8'hf0)
        rd(`IOP_OFS_LEVEL, 32'h00ffffaa, `IOP_RESP_OKAY);
        wr(`IOP_OFS_PULL, 32'h00ffff00, `IOP_RESP_OKAY);
        settle();
        `CHK(pullup_on[7:0], 8'h00)
        wr(`IOP_OFS_PULL, 32'h00ffffff, `IOP_RESP_OKAY);
    endtask

    task automatic t_bus;
        @(posedge sys_clk);
        ext_en <= 24'h000000;
        po.bus_expansion <= 1'b1;
        po.bus_drive <= 1'b1;
        po.bus_dout <= 8'h3c;
        wr(`IOP_OFS_DATA, 32'h00000081, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_out[7:0], 8'h3c)
        `CHK(pin_oe_n[7:0], 8'h00)
        rd(`IOP_OFS_DATA, 32'h00000081, `IOP_RESP_OKAY);
        @(posedge sys_clk);
        po.bus_drive <= 1'b0;
        ext_en <= 24'h0000ff;
        ext_val <= 24'h000096;
        settle();
        `CHK(pin_oe_n[7:0], 8'hff)
        `CHK(pullup_on[7:0], 8'hff)
        `CHK(pi.bus_din, 8'h96)
        wr(`IOP_OFS_PULL, 32'h00ffff0f, `IOP_RESP_OKAY);
        settle();
        `CHK(pullup_on[7:0], 8'h0f)
        wr(`IOP_OFS_PULL, 32'h00ffffff, `IOP_RESP_OKAY);
        @(posedge sys_clk);
        po <= '0;
    endtask

    task automatic t_serial;
        @(posedge sys_clk);
        ext_en <= 24'h000100;
        ext_val <= 24'h000000;
        po.serial0_use <= 4'b1011;
        po.serial0_tx <= 1'b1;
        po.serial0_ready_out <= 1'b1;
        wr(`IOP_OFS_DATA, 32'h00000000, `IOP_RESP_OKAY);
        wr(`IOP_OFS_DIR, 32'h00000f00, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_oe_n[11:8], 4'b0001)
        `CHK(pin_out[11:9], 3'b101)
        `CHK(pullup_on[8], 1'b1)
        `CHK(pullup_on[10], 1'b0)
        `CHK(pi.serial0_rx, 1'b0)
        // second mode: driven shift clock, serial1 receiving
        @(posedge sys_clk);
        po.serial0_use <= 4'b0100;
        po.serial0_clk_drive <= 1'b1;
        po.serial0_shift_clock <= 1'b1;
        po.serial1_use <= 4'b0101;
        ext_en <= 24'h005000;
        ext_val <= 24'h001000;
        settle();
        `CHK(pin_oe_n[11:8], 4'b0000)
        `CHK(pin_out[11:8], 4'b0100)
        `CHK(pi.serial0_shift_clock, 1'b1)
        `CHK({pi.serial1_rx, pi.serial1_shift_clock}, 2'b10)
        `CHK(pullup_on[15:12], 4'hf)
        @(posedge sys_clk);
        po <= '0;
    endtask

    task automatic t_alt;
        @(posedge sys_clk);
        ext_en <= 24'h100000;
        ext_val <= 24'h000000;
        wr(`IOP_OFS_DATA, 32'h00850000, `IOP_RESP_OKAY);
        wr(`IOP_OFS_DIR, 32'h00cf0000, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_out[19:16], 4'h5)
        `CHK(pin_out[23:22], 2'b10)
        @(posedge sys_clk);
        po.timer_pair_a_en <= 1'b1;
        po.timer_pair_b_en <= 1'b1;
        po.timer_pair_b_inv_en <= 1'b1;
        po.timer_pair_b_out <= 1'b1;
        po.clock_out_en <= 1'b1;
        po.display_en <= 1'b1;
        po.display_line_clock <= 1'b1;
        po.bus_release_en <= 1'b1;
        wr(`IOP_OFS_DIR, 32'h00000000, `IOP_RESP_OKAY);
        settle();
        `CHK(pin_out[19:16], 4'b0010)
        `CHK(pin_oe_n[19:16], 4'h0)
        `CHK(pullup_on[19:16], 4'h0)
        `CHK(pin_out[23:21], 3'b010)
        `CHK(pin_oe_n[23:20], 4'b0001)
        `CHK(pullup_on[20], 1'b1)
        `CHK(pi.bus_release_request, 1'b0)
        @(posedge sys_clk);
        po <= '0;
        ext_en <= 24'hf00000;
        ext_val <= 24'ha00000;
        settle();
        `CHK(pi.timer_ext_clock_in, 4'ha)
        `CHK(pullup_on[23:20], 4'hf)
        rd(`IOP_OFS_LEVEL, 32'h00afffff, `IOP_RESP_OKAY);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_gpio();
        t_bus();
        t_serial();
        t_alt();
        summarize();
    end

    // whole run needs well under 2,000 cycles
    initial begin
        #40000;
        fails++;
        summarize();
    end
endmodule
